// file: design/hber_top.sv
// Purpose: Error flags, message enables and scratch storage of the bridge
// Assumes: Event inputs are one-cycle pulses synchronous to CLK_I
// Notes: Zero-wait APB slave; read data registered in the setup cycle

`timescale 1ns/1ns
`default_nettype none

module hber_top (
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic NONDRAM_LOCK_I,
  input wire logic SW_SMI_I,
  input wire logic UNIMPL_SPECIAL_CYCLE_I,
  input wire logic OUTSIDE_APERTURE_I,
  input wire logic INVALID_AGP_ACCESS_I,
  input wire logic BAD_TABLE_ENTRY_I,
  input wire logic UNSUPPORTED_CMD_I,
  input wire logic TARGET_ABORT_I,
  output logic SERR_MSG_REQ_O,
  input wire logic SERR_MSG_ACK_I,
  output logic IRQ_O
);

  // ==========================================================================
  // Reset synchroniser
  logic rst_meta_ff;
  logic rst_n_ff;

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // ==========================================================================
  // Helpers
  function automatic logic [15:0] byte_merge(input logic [15:0] old, input logic [15:0] wdata,
                                             input logic [1:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = wdata[7:0];
    end
    if (strb[1]) begin
      res[15:8] = wdata[15:8];
    end
    return res;
  endfunction : byte_merge

  function automatic logic hit(input logic [11:0] addr, input logic [7:0] idx);
    return (addr[11:2] == {2'b00, idx}) && (addr[1:0] == 2'b00);
  endfunction : hit

  // ==========================================================================
  // APB decode
  logic setup_phase;
  logic access_done;
  logic wr_done;
  logic rd_done;
  logic sel_cmd;
  logic sel_flags;
  logic sel_en;
  logic sel_scr;
  logic sel_ist;
  logic sel_imask;
  logic mapped;
  logic [15:0] wdata16;
  logic [15:0] strb_bits;

  assign setup_phase = PSEL_I && !PENABLE_I;
  assign access_done = PSEL_I && PENABLE_I;
  assign wr_done = access_done && PWRITE_I;
  assign rd_done = access_done && !PWRITE_I;
  assign sel_cmd = hit(PADDR_I, hber_pkg::IDX_FUNC_CMD);
  assign sel_flags = hit(PADDR_I, hber_pkg::IDX_ERR_FLAGS);
  assign sel_en = hit(PADDR_I, hber_pkg::IDX_ERR_MSG_EN);
  assign sel_scr = hit(PADDR_I, hber_pkg::IDX_SCRATCH);
  assign sel_ist = hit(PADDR_I, hber_pkg::IDX_IRQ_STATUS);
  assign sel_imask = hit(PADDR_I, hber_pkg::IDX_IRQ_MASK);
  assign mapped = sel_cmd || sel_flags || sel_en || sel_scr || sel_ist || sel_imask;
  assign wdata16 = PWDATA_I[15:0];
  assign strb_bits = {{8{PSTRB_I[1]}}, {8{PSTRB_I[0]}}};

  // Zero-wait slave; an unmapped address completes with an error
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = access_done && !mapped;

  // ==========================================================================
  // Event vector in flag layout
  logic [15:0] evt_vec;

  always_comb begin
    evt_vec = 16'h0000;
    evt_vec[hber_pkg::BIT_NONDRAM_LOCK] = NONDRAM_LOCK_I;
    evt_vec[hber_pkg::BIT_SW_SMI] = SW_SMI_I;
    evt_vec[hber_pkg::BIT_UNIMPL_SC] = UNIMPL_SPECIAL_CYCLE_I;
    evt_vec[hber_pkg::BIT_OUTSIDE_AP] = OUTSIDE_APERTURE_I;
    evt_vec[hber_pkg::BIT_INVALID_AGP] = INVALID_AGP_ACCESS_I;
    evt_vec[hber_pkg::BIT_BAD_ENTRY] = BAD_TABLE_ENTRY_I;
    evt_vec[hber_pkg::BIT_UNSUP_CMD] = UNSUPPORTED_CMD_I;
  end

  // ==========================================================================
  // Error flags, write one to clear, set wins
  logic [15:0] error_flags_ff;
  logic [15:0] flags_clr;
  logic [15:0] flags_set;
  logic [15:0] nxt_error_flags;

  assign flags_clr = (wr_done && sel_flags) ? (wdata16 & strb_bits) : 16'h0000;
  assign flags_set = evt_vec & hber_pkg::FLAGS_MASK;
  assign nxt_error_flags = (error_flags_ff & ~flags_clr) | flags_set;

  always_ff @(posedge CLK_I or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      error_flags_ff <= hber_pkg::RESET_16;
    end else begin
      error_flags_ff <= nxt_error_flags;
    end
  end

  // ==========================================================================
  // Message enables, command register, scratch storage
  logic [15:0] error_message_enables_ff;
  logic [15:0] function_command_reg_ff;
  logic [15:0] scratch_storage_ff;

  always_ff @(posedge CLK_I or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      error_message_enables_ff <= hber_pkg::RESET_16;
    end else if (wr_done && sel_en) begin
      error_message_enables_ff <= byte_merge(error_message_enables_ff, wdata16, PSTRB_I[1:0])
                                  & hber_pkg::MSG_EN_MASK;
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      function_command_reg_ff <= hber_pkg::RESET_16;
    end else if (wr_done && sel_cmd) begin
      function_command_reg_ff <= byte_merge(function_command_reg_ff, wdata16, PSTRB_I[1:0])
                                 & hber_pkg::FUNC_CMD_MASK;
    end
  end

  // Storage only; nothing else reads it
  always_ff @(posedge CLK_I or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      scratch_storage_ff <= hber_pkg::RESET_16;
    end else if (wr_done && sel_scr) begin
      scratch_storage_ff <= byte_merge(scratch_storage_ff, wdata16, PSTRB_I[1:0]);
    end
  end

  // ==========================================================================
  // Hub link error message
  logic [15:0] flags_rise;
  logic global_en;
  logic msg_trigger;
  logic serr_pend_ff;

  // Only a 0-to-1 change counts; a flag already set sends nothing more
  assign flags_rise = flags_set & ~error_flags_ff;
  assign global_en = function_command_reg_ff[hber_pkg::BIT_SERR_EN];
  assign msg_trigger = global_en && (
    (|(flags_rise & error_message_enables_ff)) ||
    (TARGET_ABORT_I && error_message_enables_ff[hber_pkg::BIT_TARGET_ABORT]));

  // Triggers while a message waits merge into it; a new one beats the ack
  always_ff @(posedge CLK_I or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      serr_pend_ff <= 1'b0;
    end else if (msg_trigger) begin
      serr_pend_ff <= 1'b1;
    end else if (SERR_MSG_ACK_I) begin
      serr_pend_ff <= 1'b0;
    end
  end

  // No dedicated error pin; errors leave the block as the message request and as IRQ_O
  assign SERR_MSG_REQ_O = serr_pend_ff;

  // ==========================================================================
  // Interrupt status and mask
  logic [15:0] irq_status_ff;
  logic [15:0] irq_mask_ff;
  logic [15:0] irq_evt;

  always_comb begin
    irq_evt = flags_set;
    irq_evt[hber_pkg::BIT_TARGET_ABORT] = TARGET_ABORT_I;
  end

  always_ff @(posedge CLK_I or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      irq_status_ff <= hber_pkg::RESET_16;
    end else if (rd_done && sel_ist) begin
      // Clear only what the read reported; setup-cycle events survive
      irq_status_ff <= (irq_status_ff & ~PRDATA_O[15:0]) | irq_evt;
    end else begin
      irq_status_ff <= irq_status_ff | irq_evt;
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      irq_mask_ff <= hber_pkg::RESET_16;
    end else if (wr_done && sel_imask) begin
      irq_mask_ff <= byte_merge(irq_mask_ff, wdata16, PSTRB_I[1:0]) & hber_pkg::IRQ_MASK_BITS;
    end
  end

  assign IRQ_O = |(irq_status_ff & irq_mask_ff);

  // ==========================================================================
  // Read data, captured in the setup cycle
  logic [15:0] rd_mux;

  always_comb begin
    rd_mux = 16'h0000;
    if (sel_cmd) begin
      rd_mux = function_command_reg_ff;
    end else if (sel_flags) begin
      rd_mux = error_flags_ff;
    end else if (sel_en) begin
      rd_mux = error_message_enables_ff;
    end else if (sel_scr) begin
      rd_mux = scratch_storage_ff;
    end else if (sel_ist) begin
      rd_mux = irq_status_ff;
    end else if (sel_imask) begin
      rd_mux = irq_mask_ff;
    end
  end

  // Event arriving in the setup cycle still sets the flag after the read
  always_ff @(posedge CLK_I or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      PRDATA_O <= 32'h0000_0000;
    end else if (setup_phase && !PWRITE_I) begin
      PRDATA_O <= {16'h0000, rd_mux};
    end
  end

  // ==========================================================================
  // Assertions
  // Write of one to the SMI flag while no new SMI arrives
  sequence s_smi_clear_req;
    wr_done && sel_flags && PSTRB_I[1] && PWDATA_I[hber_pkg::BIT_SW_SMI] && !SW_SMI_I;
  endsequence

  a_flag_set_always: assert property (@(posedge CLK_I) disable iff (!rst_n_ff)
    NONDRAM_LOCK_I |=> error_flags_ff[hber_pkg::BIT_NONDRAM_LOCK])
    else $error("Lock event did not set its flag");

  a_flag_rise_msg: assert property (@(posedge CLK_I) disable iff (!rst_n_ff)
    (UNSUPPORTED_CMD_I && !error_flags_ff[hber_pkg::BIT_UNSUP_CMD] && global_en
     && error_message_enables_ff[hber_pkg::BIT_UNSUP_CMD]) |=> SERR_MSG_REQ_O)
    else $error("Rising enabled flag sent no message");

  a_flag_w1c_only: assert property (@(posedge CLK_I) disable iff (!rst_n_ff)
    (error_flags_ff[hber_pkg::BIT_BAD_ENTRY]
     && !(wr_done && sel_flags && PSTRB_I[0] && PWDATA_I[hber_pkg::BIT_BAD_ENTRY]))
    |=> error_flags_ff[hber_pkg::BIT_BAD_ENTRY])
    else $error("Flag cleared without a write of one");

  a_flag_w1c_clear: assert property (@(posedge CLK_I) disable iff (!rst_n_ff)
    s_smi_clear_req |=> !error_flags_ff[hber_pkg::BIT_SW_SMI])
    else $error("Write of one failed to clear a flag");

  a_smi_flag_src: assert property (@(posedge CLK_I) disable iff (!rst_n_ff)
    (!error_flags_ff[hber_pkg::BIT_SW_SMI] && !SW_SMI_I) |=> !error_flags_ff[hber_pkg::BIT_SW_SMI])
    else $error("SMI flag set without its source");

  a_global_gate: assert property (@(posedge CLK_I) disable iff (!rst_n_ff)
    (!global_en && !SERR_MSG_REQ_O) |=> !SERR_MSG_REQ_O)
    else $error("Message raised with global enable off");

  a_abort_msg: assert property (@(posedge CLK_I) disable iff (!rst_n_ff)
    (TARGET_ABORT_I && global_en && error_message_enables_ff[hber_pkg::BIT_TARGET_ABORT])
    |=> SERR_MSG_REQ_O)
    else $error("Target abort sent no message");

  a_unimpl_no_msg: assert property (@(posedge CLK_I) disable iff (!rst_n_ff)
    (!SERR_MSG_REQ_O && UNIMPL_SPECIAL_CYCLE_I && !error_message_enables_ff[hber_pkg::BIT_UNIMPL_SC]
     && !NONDRAM_LOCK_I && !SW_SMI_I && !OUTSIDE_APERTURE_I && !INVALID_AGP_ACCESS_I
     && !BAD_TABLE_ENTRY_I && !UNSUPPORTED_CMD_I && !TARGET_ABORT_I) |=> !SERR_MSG_REQ_O)
    else $error("Disabled event sent a message");

  a_scratch_hold: assert property (@(posedge CLK_I) disable iff (!rst_n_ff)
    !(wr_done && sel_scr) |=> $stable(scratch_storage_ff))
    else $error("Scratch changed without a write");

  a_reserved_zero: assert property (@(posedge CLK_I) disable iff (!rst_n_ff)
    ((error_flags_ff & ~hber_pkg::FLAGS_MASK) == 16'h0000)
    && ((error_message_enables_ff & ~hber_pkg::MSG_EN_MASK) == 16'h0000))
    else $error("Reserved bit became set");

  a_cmd_reserved: assert property (@(posedge CLK_I) disable iff (!rst_n_ff)
    (function_command_reg_ff & ~hber_pkg::FUNC_CMD_MASK) == 16'h0000)
    else $error("Reserved command bit became set");

  a_lock_flag_src: assert property (@(posedge CLK_I) disable iff (!rst_n_ff)
    (!error_flags_ff[hber_pkg::BIT_NONDRAM_LOCK] && !NONDRAM_LOCK_I)
    |=> !error_flags_ff[hber_pkg::BIT_NONDRAM_LOCK])
    else $error("Lock flag set without a lock event");

  a_unsup_flag_set: assert property (@(posedge CLK_I) disable iff (!rst_n_ff)
    UNSUPPORTED_CMD_I |=> error_flags_ff[hber_pkg::BIT_UNSUP_CMD])
    else $error("Unsupported command left its flag clear");

  a_lock_msg: assert property (@(posedge CLK_I) disable iff (!rst_n_ff)
    (NONDRAM_LOCK_I && !error_flags_ff[hber_pkg::BIT_NONDRAM_LOCK] && global_en
     && error_message_enables_ff[hber_pkg::BIT_NONDRAM_LOCK]) |=> SERR_MSG_REQ_O)
    else $error("Lock event sent no message");

  a_outside_msg: assert property (@(posedge CLK_I) disable iff (!rst_n_ff)
    (OUTSIDE_APERTURE_I && !error_flags_ff[hber_pkg::BIT_OUTSIDE_AP] && global_en
     && error_message_enables_ff[hber_pkg::BIT_OUTSIDE_AP]) |=> SERR_MSG_REQ_O)
    else $error("Outside aperture event sent no message");

  a_invalid_msg: assert property (@(posedge CLK_I) disable iff (!rst_n_ff)
    (INVALID_AGP_ACCESS_I && !error_flags_ff[hber_pkg::BIT_INVALID_AGP] && global_en
     && error_message_enables_ff[hber_pkg::BIT_INVALID_AGP]) |=> SERR_MSG_REQ_O)
    else $error("Invalid access event sent no message");

  a_entry_msg: assert property (@(posedge CLK_I) disable iff (!rst_n_ff)
    (BAD_TABLE_ENTRY_I && !error_flags_ff[hber_pkg::BIT_BAD_ENTRY] && global_en
     && error_message_enables_ff[hber_pkg::BIT_BAD_ENTRY]) |=> SERR_MSG_REQ_O)
    else $error("Bad table entry sent no message");

  a_unsup_no_msg: assert property (@(posedge CLK_I) disable iff (!rst_n_ff)
    (!SERR_MSG_REQ_O && UNSUPPORTED_CMD_I && !error_message_enables_ff[hber_pkg::BIT_UNSUP_CMD]
     && (evt_vec == 16'h0002) && !TARGET_ABORT_I) |=> !SERR_MSG_REQ_O)
    else $error("Disabled command event sent a message");

  a_rise_needs_global: assert property (@(posedge CLK_I) disable iff (!rst_n_ff)
    $rose(SERR_MSG_REQ_O) |-> $past(global_en))
    else $error("Message rose without global enable");

  // Accepted message with no new trigger in the same cycle
  sequence s_msg_accept;
    SERR_MSG_REQ_O && SERR_MSG_ACK_I && !msg_trigger;
  endsequence

  a_msg_ack_drop: assert property (@(posedge CLK_I) disable iff (!rst_n_ff)
    s_msg_accept |=> !SERR_MSG_REQ_O)
    else $error("Message stayed after its ack");

  a_msg_req_hold: assert property (@(posedge CLK_I) disable iff (!rst_n_ff)
    (SERR_MSG_REQ_O && !SERR_MSG_ACK_I) |=> SERR_MSG_REQ_O)
    else $error("Message dropped before its ack");

  a_scratch_write: assert property (@(posedge CLK_I) disable iff (!rst_n_ff)
    (wr_done && sel_scr && (PSTRB_I[1:0] == 2'b11))
    |=> (scratch_storage_ff == $past(PWDATA_I[15:0])))
    else $error("Scratch write did not land");

  a_irq_read_clear: assert property (@(posedge CLK_I) disable iff (!rst_n_ff)
    (rd_done && sel_ist && (irq_evt == 16'h0000))
    |=> ((irq_status_ff & $past(PRDATA_O[15:0])) == 16'h0000))
    else $error("Reported interrupt bit not cleared by read");

  // Event seen at the setup edge is not in the read data, so it must survive
  a_irq_event_kept: assert property (@(posedge CLK_I) disable iff (!rst_n_ff)
    (setup_phase && !PWRITE_I && sel_ist && UNSUPPORTED_CMD_I && !irq_status_ff[hber_pkg::BIT_UNSUP_CMD])
    |=> ##1 irq_status_ff[hber_pkg::BIT_UNSUP_CMD])
    else $error("Interrupt event lost across a status read");

endmodule : hber_top

`default_nettype wire

// file: design/hber_pkg.sv
// Purpose: Constants for the host bridge error reporting block
// Assumes: APB slave, 32-bit data, printed offsets are word indices
// Notes: Register indices, field positions and bit masks follow

package hber_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_FUNC_CMD = 8'h04;
  localparam logic [7:0] IDX_ERR_FLAGS = 8'hC8;
  localparam logic [7:0] IDX_ERR_MSG_EN = 8'hCA;
  localparam logic [7:0] IDX_SCRATCH = 8'hDE;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hE0;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hE1;

  // ==========================================================================
  // Field positions
  localparam int BIT_UNSUP_CMD = 1;
  localparam int BIT_BAD_ENTRY = 2;
  localparam int BIT_INVALID_AGP = 3;
  localparam int BIT_OUTSIDE_AP = 4;
  localparam int BIT_UNIMPL_SC = 5;
  localparam int BIT_TARGET_ABORT = 6;
  localparam int BIT_SW_SMI = 8;
  localparam int BIT_NONDRAM_LOCK = 9;
  localparam int BIT_SERR_EN = 8;

  // ==========================================================================
  // Implemented bit masks and reset values
  localparam logic [15:0] FLAGS_MASK = 16'h033E;
  localparam logic [15:0] MSG_EN_MASK = 16'h027E;
  localparam logic [15:0] FUNC_CMD_MASK = 16'h0100;
  localparam logic [15:0] IRQ_MASK_BITS = 16'h037E;
  localparam logic [15:0] RESET_16 = 16'h0000;

endpackage : hber_pkg

// file: tb/hber_hub_model.sv
// Purpose: Hub link receiver that accepts error messages
// Assumes: Request holds until the ack edge
// Notes: Ack delay is set per test, zero is prompt
`timescale 1ns/1ns
`default_nettype none
module hber_hub_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire logic [3:0] delay_i,
  output logic ack_o,
  output logic [7:0] cnt_o
);
  logic [3:0] wait_ff;
  // ====================
  // Acceptance
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_o <= 1'b0;
      cnt_o <= 8'h00;
      wait_ff <= 4'h0;
    end else begin
      ack_o <= 1'b0;
      if (req_i && !ack_o) begin
        if (wait_ff == delay_i) begin
          ack_o <= 1'b1;
          cnt_o <= cnt_o + 8'h01;
          wait_ff <= 4'h0;
        end else begin
          wait_ff <= wait_ff + 4'h1;
        end
      end
    end
  end
endmodule : hber_hub_model
`default_nettype wire

// file: tb/hber_tb_top.sv
// Purpose: Self-checking bench of the error reporting block
// Assumes: Zero-wait APB slave, hub model acks messages
// Notes: Table loop first, then the awkward cases
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module host_bridge_error_reporting_tb_top;
  typedef struct {logic [15:0] flag; logic [7:0] msgs;} hber_row_s;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [15:0] pwdata = 16'h0000;
  logic [7:0] ev = 8'h00;
  logic [3:0] dly = 4'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, req, ack, irq, err;
  logic [7:0] cnt, c0;
  int num_errors = 0;
  int cmp_count = 0;
  // Event order: lock, smi, special cycle, outside, invalid, entry, command, abort
  hber_row_s rows [8] = '{'{16'h0200, 8'h01}, '{16'h0100, 8'h00}, '{16'h0020, 8'h01}, '{16'h0010, 8'h01},
    '{16'h0008, 8'h01}, '{16'h0004, 8'h01}, '{16'h0002, 8'h01}, '{16'h0000, 8'h01}};

  always #5 clk = ~clk;

  hber_top dut (.CLK_I(clk), .ARST_N_I(arst_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I({16'h0000, pwdata}), .PSTRB_I(4'hF), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .NONDRAM_LOCK_I(ev[0]), .SW_SMI_I(ev[1]), .UNIMPL_SPECIAL_CYCLE_I(ev[2]),
    .OUTSIDE_APERTURE_I(ev[3]), .INVALID_AGP_ACCESS_I(ev[4]), .BAD_TABLE_ENTRY_I(ev[5]),
    .UNSUPPORTED_CMD_I(ev[6]), .TARGET_ABORT_I(ev[7]), .SERR_MSG_REQ_O(req), .SERR_MSG_ACK_I(ack), .IRQ_O(irq));

  hber_hub_model hub (.clk_i(clk), .rst_n_i(arst_n), .req_i(req), .delay_i(dly), .ack_o(ack), .cnt_o(cnt));

  // ====================
  // Tasks
  task automatic wrap_up;
    if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        num_errors++;
        wrap_up();
      end
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rd_chk(input logic [11:0] a, input logic [15:0] e);
    apb(1'b0, a, 16'h0000);
    `CHK(rd, {16'h0000, e})
  endtask : rd_chk

  task automatic fire(input int i);
    ev <= 8'h01 << i;
    @(posedge clk);
    ev <= 8'h00;
    @(posedge clk);
  endtask : fire

  // Bounded wait until no message is pending
  task automatic drain;
    int n;
    n = 0;
    @(posedge clk);
    while (req !== 1'b0) begin
      n++;
      if (n > 40) begin
        num_errors++;
        wrap_up();
      end
      @(posedge clk);
    end
  endtask : drain

  // ====================
  // Sequence
  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk(12'h320, 16'h0000);
    rd_chk(12'h328, 16'h0000);
    rd_chk(12'h378, 16'h0000);
    apb(1'b1, 12'h010, 16'h0100);
    apb(1'b1, 12'h328, 16'hFFFF);
    rd_chk(12'h328, 16'h027E);
    for (int i = 0; i < 8; i++) begin
      dly <= 4'(i);
      c0 = cnt;
      fire(i);
      rd_chk(12'h320, rows[i].flag);
      drain();
      `CHK(cnt - c0, rows[i].msgs)
      apb(1'b1, 12'h320, rows[i].flag);
      rd_chk(12'h320, 16'h0000);
    end
    // Repeat on a set flag, then a write of zero
    dly <= 4'hF;
    c0 = cnt;
    fire(3);
    fire(3);
    drain();
    `CHK(cnt - c0, 8'h01)
    apb(1'b1, 12'h320, 16'h0000);
    rd_chk(12'h320, 16'h0010);
    apb(1'b1, 12'h320, 16'hFFFF);
    rd_chk(12'h320, 16'h0000);
    // Enables off
    apb(1'b1, 12'h328, 16'h0000);
    c0 = cnt;
    fire(6);
    fire(2);
    drain();
    `CHK(cnt - c0, 8'h00)
    rd_chk(12'h320, 16'h0022);
    apb(1'b1, 12'h320, 16'h0022);
    // Global enable off
    apb(1'b1, 12'h328, 16'hFFFF);
    apb(1'b1, 12'h010, 16'h0000);
    c0 = cnt;
    fire(0);
    fire(7);
    drain();
    `CHK(cnt - c0, 8'h00)
    rd_chk(12'h320, 16'h0200);
    apb(1'b1, 12'h320, 16'h0200);
    // Scratch storage has no side effect
    apb(1'b1, 12'h378, 16'hA5C3);
    rd_chk(12'h378, 16'hA5C3);
    rd_chk(12'h320, 16'h0000);
    // Unmapped address
    apb(1'b0, 12'h3FC, 16'h0000);
    `CHK({err, rd}, {1'b1, 32'h0})
    // Interrupt raise, mask, read-clear
    apb(1'b0, 12'h380, 16'h0000);
    apb(1'b1, 12'h384, 16'h0002);
    fire(6);
    `CHK(irq, 1'b1)
    apb(1'b1, 12'h384, 16'h0000);
    `CHK(irq, 1'b0)
    apb(1'b1, 12'h384, 16'h0002);
    `CHK(irq, 1'b1)
    rd_chk(12'h380, 16'h0002);
    `CHK(irq, 1'b0)
    // Reset in mid-run returns every register to zero
    apb(1'b1, 12'h378, 16'h5A3C);
    fire(0);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK({req, irq, prdata}, 34'h0)
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk(12'h378, 16'h0000);
    rd_chk(12'h320, 16'h0000);
    rd_chk(12'h010, 16'h0000);
    wrap_up();
  end
endmodule : host_bridge_error_reporting_tb_top
`default_nettype wire
